// *** mfepf_pkg.sv ***
/*
   Constants, field values and carrier types for the mirror fault event packet framer.
   Assumes a single core clock domain; every file of the framer but the sink model imports this package whole.
*/
package mfepf_pkg;

   // ----------------------------------------------------------------------
   // Primary header fixed fields
   // ----------------------------------------------------------------------
   localparam logic [2:0]  PKT_VERSION   = 3'h0;
   localparam logic        PKT_TYPE      = 1'b0;
   localparam logic        DFH_FLAG      = 1'b1;
   localparam logic [6:0]  APP_ID        = 7'h47;     // Application identifier 71.
   localparam logic [3:0]  PKT_CATEGORY  = 4'h7;      // Event category.
   localparam logic [1:0]  SEG_FLAGS     = 2'h3;
   localparam int          SEQ_W         = 14;
   localparam logic [13:0] SEQ_RESET     = 14'h0000;
   localparam logic [15:0] LEN_BASE      = 16'h0009;

   // ----------------------------------------------------------------------
   // Service header fixed fields
   // ----------------------------------------------------------------------
   localparam logic [2:0]  SVC_VERSION   = 3'h2;      // Non-science data.
   localparam logic        CHKSUM_FLAG   = 1'b0;
   localparam logic [3:0]  HDR_SPARE     = 4'h0;
   localparam logic [7:0]  SVC_TYPE      = 8'h05;     // Event report.
   localparam logic [7:0]  SVC_SUBTYPE   = 8'h03;     // Ground action needed.
   localparam logic [7:0]  HDR_PAD       = 8'h00;

   // ----------------------------------------------------------------------
   // Source data
   // ----------------------------------------------------------------------
   localparam logic [15:0] EID_NOSPACE   = 16'hA7FC;  // 43004.
   localparam logic [15:0] EID_REPEAT    = 16'hA7FD;  // 43005.
   localparam logic [15:0] POS_SPACE     = 16'h0001;
   localparam logic [15:0] POS_HOT       = 16'h0002;
   localparam logic [15:0] POS_COLD      = 16'h0003;
   localparam logic [15:0] SRC_NOSPACE   = 16'h0002;  // Source data bytes.
   localparam logic [15:0] SRC_REPEAT    = 16'h0004;
   localparam logic [4:0]  PKT_BYTES_NOSPACE = 5'h12; // 16 header bytes plus 2.
   localparam logic [4:0]  PKT_BYTES_REPEAT  = 5'h14; // 16 header bytes plus 4.
   localparam int          PKT_BITS      = 160;
   localparam int          FIFO_DEPTH    = 8;

   // ----------------------------------------------------------------------
   // Carrier types and states
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [31:0] sec;
      logic [15:0] frac;
   } mfepf_time_s;

   typedef struct packed {
      logic       last;
      logic [7:0] data;
   } mfepf_byte_s;

   typedef enum logic [1:0] {TRK_IDLE, TRK_MISSED, TRK_BACK, TRK_NOSPACE} mfepf_track_e;
   typedef enum logic {SER_IDLE, SER_SEND} mfepf_ser_e;

endpackage : mfepf_pkg

// *** mfepf_fifo.sv ***
/*
   Small synchronous FIFO with valid and ready on both sides.
   Assumes one clock and an asynchronous active-high reset shared with the framer.
*/
`timescale 1ns/10ps
module mfepf_fifo
   import mfepf_pkg::*;
#(
   parameter int W = 9,
   parameter int D = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic [W-1:0]      out_data,
   output logic              out_valid,
   input  wire logic         out_ready
);

   localparam int AW = (D > 1) ? $clog2(D) : 1;

   logic [W-1:0] mem [D];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0]   count;
   logic          do_wr;
   logic          do_rd;

   // Full and empty come straight from the occupancy count.
   // The depth is cast to the count's width; a pointer-wide cast would wrap to zero.
   assign in_ready  = (count != (AW+1)'(D));
   assign out_valid = (count != '0);
   assign do_wr     = in_valid & in_ready;
   assign do_rd     = out_valid & out_ready;
   assign out_data  = mem[rd_ptr];

   // Storage; no reset is needed because unread words are never shown.
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // Pointers wrap explicitly so that a depth that is not a power of two still works.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == AW'(D - 1)) ? '0 : wr_ptr + AW'(1);
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == AW'(D - 1)) ? '0 : rd_ptr + AW'(1);
         end
      end
   end

   // Occupancy.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count <= '0;
      end else if (do_wr && !do_rd) begin
         count <= count + (AW+1)'(1);
      end else if (do_rd && !do_wr) begin
         count <= count - (AW+1)'(1);
      end
   end

endmodule : mfepf_fifo

// *** mfepf_framer.sv ***
/*
   Mirror fault event packet framer: tracks the calibration mirror fault sequence, builds the
   event report packets and streams them out a byte at a time through an 8-word FIFO.
   Assumes the mirror and spectrometer status pins are asynchronous, the acquisition time
   arrives from logic on CORE_CLK, and the telemetry sink applies back-pressure with TX_READY.
*/
// How it works
// - A 14-bit sequence count starts at zero and steps by one per packet, one counter per application and category pair.
// - The packet length field holds the source data size in bytes plus nine.
// - A 48-bit acquisition time, four bytes of seconds then two of fraction, is placed in each packet.
// - The packet category field is always the event code 7.
// - The service header version field is binary 010 for non-science data.
// - The service type field is 5, an event report.
// - The service subtype field is 3, ground action required.
// - Event 43004 is sent after target miss, drive back, space miss and an actuator firing that still finds no space.
// - Event 43005 is sent when a mirror failure follows recovery from an earlier one.
// - The repeat report appends a 16-bit failed position word: 1 space, 2 hot, 3 cold.
// - The repeat report has four bytes of source data and a length field of 13.
// - A spectrometer error is raised when the busy line is still high at the moment the scan should have ended.
// - The no-space report carries only the event identifier and has a length field of 11.
`timescale 1ns/10ps
module mfepf_framer
   import mfepf_pkg::*;
(
   input  wire logic         CORE_CLK,
   input  wire logic         RST,
   input  wire logic         MISS_TARGET,
   input  wire logic         DRIVEN_BACK,
   input  wire logic         MISS_SPACE,
   input  wire logic         RELEASE_FIRED,
   input  wire logic         SPACE_FOUND,
   input  wire logic [1:0]   TARGET_POS,
   input  wire logic         SPEC_BUSY,
   input  wire logic         SCAN_END_DUE,
   input  wire mfepf_time_s  ACQ_TIME,
   output logic [7:0]        TX_DATA,
   output logic              TX_VALID,
   output logic              TX_LAST,
   input  wire logic         TX_READY,
   output logic [13:0]       SEQ_COUNT,
   output logic              RECOVERED,
   output logic              FRAMER_BUSY,
   output logic              SPEC_ERR,
   output logic              EVENT_LOST
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------

   // Maps the two-bit position code onto the 16-bit failed position word.
   function automatic logic [15:0] pos_word(input logic [1:0] code);
      case (code)
         2'h2:    pos_word = POS_HOT;
         2'h3:    pos_word = POS_COLD;
         default: pos_word = POS_SPACE;
      endcase
   endfunction : pos_word

   // Builds the whole packet left aligned; the no-space packet leaves its last word unsent.
   function automatic logic [PKT_BITS-1:0] build_pkt(input logic        rep,
                                                     input logic [13:0] seq,
                                                     input mfepf_time_s t,
                                                     input logic [15:0] pos);
      logic [15:0] len;
      logic [15:0] eid;
      logic [15:0] tail;
      len  = LEN_BASE + (rep ? SRC_REPEAT : SRC_NOSPACE);
      eid  = rep ? EID_REPEAT : EID_NOSPACE;
      tail = rep ? pos : 16'h0000;
      build_pkt = {PKT_VERSION, PKT_TYPE, DFH_FLAG, APP_ID,
                   PKT_CATEGORY, SEG_FLAGS, seq, len,
                   t,
                   SVC_VERSION, CHKSUM_FLAG, HDR_SPARE,
                   SVC_TYPE, SVC_SUBTYPE, HDR_PAD,
                   eid, tail};
   endfunction : build_pkt

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   localparam int NPIN = 9;

   logic [NPIN-1:0] pin_meta;
   logic [NPIN-1:0] pin_sync;
   logic [NPIN-1:0] pin_prev;
   logic [NPIN-1:0] pin_rise;

   // Two flops per pin; the position code is assumed steady around a target miss.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         pin_meta <= '0;
         pin_sync <= '0;
         pin_prev <= '0;
      end else begin
         pin_meta <= {TARGET_POS, SCAN_END_DUE, SPEC_BUSY, SPACE_FOUND, RELEASE_FIRED,
                      MISS_SPACE, DRIVEN_BACK, MISS_TARGET};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
      end
   end

   assign pin_rise = pin_sync & ~pin_prev;

   logic       miss_rise;
   logic       back_rise;
   logic       nospace_rise;
   logic       fired_rise;
   logic       found_lvl;
   logic       busy_lvl;
   logic       scan_due_rise;
   logic [1:0] pos_code;

   assign miss_rise     = pin_rise[0];
   assign back_rise     = pin_rise[1];
   assign nospace_rise  = pin_rise[2];
   assign fired_rise    = pin_rise[3];
   assign found_lvl     = pin_sync[4];
   assign busy_lvl      = pin_sync[5];
   assign scan_due_rise = pin_rise[6];
   assign pos_code      = pin_sync[8:7];

   // ----------------------------------------------------------------------
   // Mirror fault sequence tracker
   // ----------------------------------------------------------------------
   mfepf_track_e trk;
   mfepf_time_s  acq_time;
   logic         set_nf;
   logic         set_rep;
   logic         recover;

   // Failure and recovery events are decoded from the tracker state, the pin edges, found_lvl and RECOVERED.
   assign set_nf  = (trk == TRK_NOSPACE) && fired_rise && !found_lvl;
   assign set_rep = (trk == TRK_IDLE) && miss_rise && RECOVERED;
   assign recover = ((trk == TRK_BACK) || (trk == TRK_NOSPACE)) && found_lvl;

   // The sequence must arrive in order; an out-of-order edge is simply ignored.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         trk <= TRK_IDLE;
      end else begin
         case (trk)
            TRK_IDLE: begin
               if (miss_rise) begin
                  trk <= TRK_MISSED;
               end
            end
            TRK_MISSED: begin
               if (back_rise) begin
                  trk <= TRK_BACK;
               end
            end
            TRK_BACK: begin
               if (recover) begin
                  trk <= TRK_IDLE;
               end else if (nospace_rise) begin
                  trk <= TRK_NOSPACE;
               end
            end
            TRK_NOSPACE: begin
               if (fired_rise || recover) begin
                  trk <= TRK_IDLE;
               end
            end
            default: trk <= TRK_IDLE;
         endcase
      end
   end

   // Recovery memory: set by a recovery, dropped by the unrecovered failure.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         RECOVERED <= 1'b0;
      end else if (recover) begin
         RECOVERED <= 1'b1;
      end else if (set_nf) begin
         RECOVERED <= 1'b0;
      end
   end

   // The first target miss opens the acquisition, so its time stamps the whole report.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         acq_time <= '0;
      end else if ((trk == TRK_IDLE) && miss_rise) begin
         acq_time <= ACQ_TIME;
      end
   end

   // ----------------------------------------------------------------------
   // Pending reports
   // ----------------------------------------------------------------------
   mfepf_ser_e  ser;
   logic        pend_nf;
   logic        pend_rep;
   mfepf_time_s nf_time;
   mfepf_time_s rep_time;
   logic [15:0] rep_pos;
   logic        take_nf;
   logic        take_rep;

   assign take_nf  = (ser == SER_IDLE) && pend_nf;
   assign take_rep = (ser == SER_IDLE) && !pend_nf && pend_rep;

   // A report raised in the cycle its flag is taken stays pending: set beats clear.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         pend_nf  <= 1'b0;
         pend_rep <= 1'b0;
      end else begin
         pend_nf  <= (pend_nf & ~take_nf) | set_nf;
         pend_rep <= (pend_rep & ~take_rep) | set_rep;
      end
   end

   // Report fields are latched with their event so a busy framer cannot mix them up.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         nf_time  <= '0;
         rep_time <= '0;
         rep_pos  <= POS_SPACE;
      end else begin
         if (set_nf) begin
            nf_time <= acq_time;
         end
         if (set_rep) begin
            rep_time <= ACQ_TIME;
            rep_pos  <= pos_word(pos_code);
         end
      end
   end

   // Only one report of each kind can wait; a second one overwrites the waiting report's fields and is flagged.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         EVENT_LOST <= 1'b0;
      end else if ((set_nf && pend_nf && !take_nf) || (set_rep && pend_rep && !take_rep)) begin
         EVENT_LOST <= 1'b1;
      end
   end

   // ----------------------------------------------------------------------
   // Spectrometer busy check
   // ----------------------------------------------------------------------

   // The busy line should be low by the time the scan end is due.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         SPEC_ERR <= 1'b0;
      end else begin
         SPEC_ERR <= scan_due_rise && busy_lvl;
      end
   end

   // ----------------------------------------------------------------------
   // Serializer and sequence count
   // ----------------------------------------------------------------------
   logic [PKT_BITS-1:0] shreg;
   logic [4:0]          bytes_left;
   mfepf_byte_s         fifo_in;
   logic                fifo_in_valid;
   logic                fifo_in_ready;
   logic                push;
   mfepf_byte_s         fifo_out;

   assign fifo_in_valid = (ser == SER_SEND);
   assign fifo_in.last  = (bytes_left == 5'h01);
   assign fifo_in.data  = shreg[PKT_BITS-1 -: 8];
   assign push          = fifo_in_valid && fifo_in_ready;

   // Serializer control; a full FIFO stalls the byte shifting.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ser        <= SER_IDLE;
         shreg      <= '0;
         bytes_left <= '0;
      end else begin
         case (ser)
            SER_IDLE: begin
               if (take_nf) begin
                  shreg      <= build_pkt(1'b0, SEQ_COUNT, nf_time, 16'h0000);
                  bytes_left <= PKT_BYTES_NOSPACE;
                  ser        <= SER_SEND;
               end else if (take_rep) begin
                  shreg      <= build_pkt(1'b1, SEQ_COUNT, rep_time, rep_pos);
                  bytes_left <= PKT_BYTES_REPEAT;
                  ser        <= SER_SEND;
               end
            end
            SER_SEND: begin
               if (push) begin
                  shreg      <= {shreg[PKT_BITS-9:0], 8'h00};
                  bytes_left <= bytes_left - 5'h01;
                  if (fifo_in.last) begin
                     ser <= SER_IDLE;
                  end
               end
            end
            default: ser <= SER_IDLE;
         endcase
      end
   end

   // All reports share the event category of one application, hence one counter; it wraps at 14 bits.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         SEQ_COUNT <= SEQ_RESET;
      end else if (take_nf || take_rep) begin
         SEQ_COUNT <= SEQ_COUNT + 14'h0001;
      end
   end

   assign FRAMER_BUSY = (ser == SER_SEND);

   // ----------------------------------------------------------------------
   // Output FIFO
   // ----------------------------------------------------------------------
   mfepf_fifo #(
      .W (9),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .clk       (CORE_CLK),
      .rst       (RST),
      .in_data   (fifo_in),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (TX_VALID),
      .out_ready (TX_READY)
   );

   assign TX_DATA = fifo_out.data;
   assign TX_LAST = fifo_out.last;

endmodule : mfepf_framer

// *** mfepf_monitor.sv ***
/*
   Port checker for the mirror fault event packet framer.
   Assumes it is bound to mfepf_framer and sees only its ports.
*/
`timescale 1ns/10ps
module mfepf_monitor
   import mfepf_pkg::*;
(
   input wire logic        CORE_CLK,
   input wire logic        RST,
   input wire logic        SPEC_BUSY,
   input wire logic [7:0]  TX_DATA,
   input wire logic        TX_VALID,
   input wire logic        TX_LAST,
   input wire logic        TX_READY,
   input wire logic [13:0] SEQ_COUNT,
   input wire logic        SPEC_ERR
);
   // -------------------------------------------------------------
   // Helper logic
   // -------------------------------------------------------------
   logic [4:0] idx;
   logic [7:0] len_b;
   wire logic  acc = TX_VALID && TX_READY;

   // Byte position inside the packet, cleared after the last byte.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) idx <= 5'h0;
      else if (acc) idx <= TX_LAST ? 5'h0 : idx + 5'h1;
   end

   // Low length byte, kept so the packet end can be judged by it.
   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) len_b <= 8'h00;
      else if (acc && idx == 5'h5) len_b <= TX_DATA;
   end

   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   // -------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------
   property p_hold; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST); endproperty
   a_hold: assert property (p_hold) else $error("stalled byte changed");
   property p_head; TX_VALID && idx == 5'h0 |-> TX_DATA == 8'h0C; endproperty
   a_head: assert property (p_head) else $error("first header byte wrong");
   property p_cat; TX_VALID && idx == 5'h1 |-> TX_DATA == 8'h77; endproperty
   a_cat: assert property (p_cat) else $error("category byte wrong");
   property p_seg; TX_VALID && idx == 5'h2 |-> TX_DATA[7:6] == 2'b11; endproperty
   a_seg: assert property (p_seg) else $error("segmentation bits wrong");
   property p_end; TX_VALID && TX_LAST |-> (idx == 5'd17 && len_b == 8'h0B) || (idx == 5'd19 && len_b == 8'h0D);
   endproperty
   a_end: assert property (p_end) else $error("packet end disagrees with length");
   property p_svc; TX_VALID && idx == 5'd12 |-> TX_DATA == 8'h40; endproperty
   a_svc: assert property (p_svc) else $error("service version byte wrong");
   property p_type; TX_VALID && idx == 5'd13 |-> TX_DATA == 8'h05; endproperty
   a_type: assert property (p_type) else $error("service type wrong");
   property p_sub; TX_VALID && idx == 5'd14 |-> TX_DATA == 8'h03; endproperty
   a_sub: assert property (p_sub) else $error("service subtype wrong");
   property p_eid; TX_VALID && idx == 5'd16 |-> TX_DATA == 8'hA7; endproperty
   a_eid: assert property (p_eid) else $error("event id high byte wrong");
   property p_seq; !$stable(SEQ_COUNT) |-> SEQ_COUNT == 14'($past(SEQ_COUNT) + 14'h1); endproperty
   a_seq: assert property (p_seq) else $error("sequence count skipped");
   property p_spec; SPEC_ERR |=> !SPEC_ERR; endproperty
   a_spec: assert property (p_spec) else $error("spectrometer error too long");
   // The pulse comes three edges after the pins are sampled, so busy must have been high then.
   property p_spec_busy; SPEC_ERR |-> $past(SPEC_BUSY, 3); endproperty
   a_spec_busy: assert property (p_spec_busy) else $error("spectrometer error without busy");

   c_rep: cover property (acc && TX_LAST && len_b == 8'h0D);
   c_nosp: cover property (acc && TX_LAST && len_b == 8'h0B);
   c_stall: cover property (TX_VALID && !TX_READY);
   c_spec: cover property (SPEC_ERR);
endmodule : mfepf_monitor

bind mfepf_framer mfepf_monitor mfepf_monitor_inst (.CORE_CLK, .RST, .SPEC_BUSY, .TX_DATA,
   .TX_VALID, .TX_LAST, .TX_READY, .SEQ_COUNT, .SPEC_ERR);

// *** mfepf_sink.sv ***
/*
   Telemetry sink model that accepts bytes, promptly or with random stalls.
   Assumes the bench seeds the random generator and drives stall.
*/
`timescale 1ns/10ps
module mfepf_sink (
   input wire logic clk,
   input wire logic rst,
   input wire logic stall,
   output logic     ready
);
   // Ready moves on the falling edge; stalling holds it low three times in four to fill the FIFO.
   always @(negedge clk or posedge rst) begin
      if (rst) ready <= 1'b0;
      else ready <= stall ? ($urandom_range(3) == 0) : 1'b1;
   end
endmodule : mfepf_sink

// *** tb_top.sv ***
/*
   Self-checking bench for the framer with a byte-level packet model.
   Assumes the sink model and the bound checker are compiled before it.
*/
`timescale 1ns/10ps
module tb_top;
   import mfepf_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   logic [4:0]  ev       = 5'h0;
   logic        sf = 1'b0, busy = 1'b0, stall = 1'b0;
   logic [1:0]  pos = 2'h0;
   mfepf_time_s acq = '0, a0;
   logic [7:0]  tx_data;
   logic        tx_valid, tx_last, tx_ready, recovered, fbusy, spec_err, lost;
   logic [13:0] seq_count;
   int          fail_count = 0, compares = 0, seq_m = 0, spec_n = 0;
   logic [8:0]  rx[$];

   always #2.5 core_clk = ~core_clk;

   mfepf_framer mfepf_framer_inst (.CORE_CLK(core_clk), .RST(rst), .MISS_TARGET(ev[0]), .DRIVEN_BACK(ev[1]),
      .MISS_SPACE(ev[2]), .RELEASE_FIRED(ev[3]), .SPACE_FOUND(sf), .TARGET_POS(pos), .SPEC_BUSY(busy),
      .SCAN_END_DUE(ev[4]), .ACQ_TIME(acq), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_LAST(tx_last),
      .TX_READY(tx_ready), .SEQ_COUNT(seq_count), .RECOVERED(recovered), .FRAMER_BUSY(fbusy),
      .SPEC_ERR(spec_err), .EVENT_LOST(lost));
   mfepf_sink mfepf_sink_inst (.clk(core_clk), .rst(rst), .stall(stall), .ready(tx_ready));

   // Accepted bytes and error pulses are collected at the sampling edge.
   always @(posedge core_clk) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1) rx.push_back({tx_last, tx_data});
      if (spec_err === 1'b1) spec_n++;
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test

   // Pins are held four cycles each way, well above the two the synchronisers need.
   task automatic pin(input int i);
      ev[i] = 1'b1;
      repeat (4) @(negedge core_clk);
      ev[i] = 1'b0;
      repeat (4) @(negedge core_clk);
   endtask : pin

   // Builds the expected packet from field values and compares it byte by byte.
   task automatic expect_pkt(input logic [15:0] eid, input logic [15:0] p, input bit rep, input mfepf_time_s t);
      logic [159:0] b;
      logic [8:0]   r;
      int           n;
      n = rep ? 20 : 18;
      b = {3'b000, 1'b0, 1'b1, 7'd71, 4'd7, 2'b11, 14'(seq_m), 16'(n - 7), t, 3'b010, 1'b0, 4'h0, 8'h05,
           8'h03, 8'h00, eid, p};
      seq_m++;
      for (int k = 0; k < 3000 && rx.size() < n; k++) @(negedge core_clk);
      if (rx.size() < n) begin
         chk("packet byte count", 16'(rx.size()), 16'(n));
         end_of_test();
      end
      for (int i = 0; i < n; i++) begin
         r = rx.pop_front();
         chk("tx byte", {8'h00, r[7:0]}, {8'h00, b[159 - 8 * i -: 8]});
         chk("tx last", {15'h0, r[8]}, {15'h0, i == n - 1});
      end
   endtask : expect_pkt

   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      void'($urandom(32'h0000_e6b4));
      repeat (4) @(negedge core_clk);
      rst = 1'b0;
      repeat (3) @(negedge core_clk);

      // Full failure chain with no space found.
      acq = {$urandom, 16'($urandom)};
      a0 = acq;
      pin(0);
      acq = {$urandom, 16'($urandom)};
      pin(1);
      pin(2);
      pin(3);
      expect_pkt(16'hA7FC, 16'h0000, 1'b0, a0);
      $display("test no_space done");

      // Steps out of order must build nothing.
      pin(2);
      pin(3);
      repeat (30) @(negedge core_clk);
      chk("stray packet", 16'(rx.size()), 16'h0000);
      $display("test out_of_order done");

      // Recover, then fail again at every position code, with a stalling sink.
      stall = 1'b1;
      pin(0);
      for (int k = 0; k < 4; k++) begin
         pin(1);
         sf = 1'b1;
         repeat (4) @(negedge core_clk);
         sf = 1'b0;
         pos = 2'(k);
         repeat (4) @(negedge core_clk);
         chk("recovered", {15'h0, recovered}, 16'h0001);
         acq = {$urandom, 16'($urandom)};
         a0 = acq;
         pin(0);
         // Twenty bytes cannot all have been pushed eight cycles after the miss.
         chk("framer busy", {15'h0, fbusy}, 16'h0001);
         expect_pkt(16'hA7FD, (k == 0) ? 16'h0001 : 16'(k), 1'b1, a0);
      end
      stall = 1'b0;
      chk("framer idle", {15'h0, fbusy}, 16'h0000);
      $display("test repeat_failure done");

      // Scan end with the spectrometer still busy, then idle.
      spec_n = 0;
      busy = 1'b1;
      pin(4);
      chk("spec error pulses", 16'(spec_n), 16'h0001);
      busy = 1'b0;
      pin(4);
      chk("spec error pulses", 16'(spec_n), 16'h0001);
      chk("seq count", {2'b00, seq_count}, 16'(seq_m));
      chk("event lost", {15'h0, lost}, 16'h0000);
      $display("test spectrometer done");
      end_of_test();
   end
endmodule : tb_top
